// file: hw/ccp_alu.sv
// ccp_alu: 8-bit combinational arithmetic unit
// assumes the core holds operands stable through phases three and four
`timescale 1ns/1ps
`default_nettype none

module ccp_alu
  import ccp_pkg::*;
(
  input  wire ccp_alu_e   op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic [2:0] bsel,
  input  wire logic       c_in,
  output logic [7:0]      y,
  output logic            c_out,
  output logic            dc_out,
  output logic            z_out
);

  // ==========================================================
  // shared adder: subtract is b + ~a + 1, so carry means no borrow
  wire logic       sub  = (op == ALU_SUB);                          // RQ12
  wire logic [7:0] a_op = sub ? ~a : a;
  wire logic [4:0] lo   = {1'b0, b[3:0]} + {1'b0, a_op[3:0]} + {4'h0, sub};
  wire logic [8:0] sum  = {1'b0, b} + {1'b0, a_op} + {8'h00, sub};
  wire logic [7:0] mask = 8'h01 << bsel;
  wire logic       arith = (op == ALU_ADD) || sub;

  // result select
  always_comb begin
    unique case (op)
      ALU_ADD, ALU_SUB: y = sum[7:0];                               // RQ11
      ALU_AND: y = a & b;
      ALU_IOR: y = a | b;
      ALU_XOR: y = a ^ b;
      ALU_COM: y = ~b;
      ALU_DEC: y = b - 8'h01;
      ALU_INC: y = b + 8'h01;
      ALU_PSB: y = b;
      ALU_PSA: y = a;
      ALU_RLF: y = {b[6:0], c_in};
      ALU_RRF: y = {c_in, b[7:1]};
      ALU_SWP: y = {b[3:0], b[7:4]};
      ALU_CLR: y = 8'h00;
      ALU_BCL: y = b & ~mask;
      ALU_BST: y = b | mask;
    endcase
  end

  // flags: shifts carry out through c, adder gives inverted borrows
  assign c_out  = arith ? sum[8] :
                  (op == ALU_RLF) ? b[7] :
                  (op == ALU_RRF) ? b[0] : c_in;                    // RQ15
  assign dc_out = lo[4];                                            // RQ15
  assign z_out  = (y == 8'h00);

endmodule : ccp_alu

`default_nettype wire

// file: hw/ccp_core.sv
// ccp_core: phase generator, two-stage fetch/execute pipeline and
// accumulator-based execute unit of the small 8-bit core
// assumes program memory answers prog_data by the end of phase four and
// the data memory answers dmem_rdata combinationally while dreq.rd is high
`timescale 1ns/1ps
`default_nettype none

module ccp_core
  import ccp_pkg::*;
#(
  parameter int unsigned PMEM_AW     = 11, // implemented program words = 2**PMEM_AW
  parameter int unsigned STACK_DEPTH = 8
)(
  input  wire logic        ref_clk,        // oscillator input
  input  wire logic        nrst,           // master clear, active low
  input  wire logic        clk_en,
  input  wire logic        resistor_capacitor_oscillator_mode,
  input  wire logic [13:0] prog_data,
  input  wire logic [7:0]  dmem_rdata,
  input  wire logic        int_req,        // already masked by the interrupt logic
  output var  ccp_preq_s   preq,
  output var  ccp_dreq_s   dreq,
  output logic             phase_one,
  output logic             phase_two,
  output logic             phase_three,
  output logic             phase_four,
  output logic             oscillator_output_cycle_clock,
  output logic             int_ack,
  output logic             retfie_pulse
);

  localparam int unsigned SP_W = $clog2(STACK_DEPTH);
  localparam logic [12:0] PC_MASK = 13'((1 << PMEM_AW) - 1);

  // ==========================================================
  // elaboration checks
  if (PHASE_COUNT != 4) begin : g_bad_phase                        // RQ10
    $error("instruction cycle must be four oscillator periods");
  end
  if (PMEM_AW < 1 || PMEM_AW > 13) begin : g_bad_aw
    $error("program address width must be 1..13");
  end
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_stk
    $error("stack depth must be a power of two, at least 2");
  end

  // ==========================================================
  // decode
  function automatic ccp_dec_s ccp_decode(input logic [13:0] i);
    ccp_dec_s d;
    d = '0;
    d.op = ALU_PSB;
    d.flow = FL_SEQ;
    unique case (i[13:12])
      2'b00: begin
        d.rd_f = 1'b1;
        d.wr_f = i[7];
        d.wr_w = ~i[7];
        unique case (i[11:8])
          4'h0: begin
            d.op = ALU_PSA;
            d.rd_f = 1'b0;
            d.wr_w = 1'b0;
            if (i[7:0] == 8'h08) d.flow = FL_RET;
            if (i[7:0] == 8'h09) d.flow = FL_RETFIE;
          end
          4'h1: begin
            d.op = ALU_CLR;
            d.rd_f = 1'b0;
            d.fz = 1'b1;
          end
          4'h2: {d.op, d.fc, d.fdc, d.fz} = {ALU_SUB, 3'b111};
          4'h3: {d.op, d.fz} = {ALU_DEC, 1'b1};
          4'h4: {d.op, d.fz} = {ALU_IOR, 1'b1};
          4'h5: {d.op, d.fz} = {ALU_AND, 1'b1};
          4'h6: {d.op, d.fz} = {ALU_XOR, 1'b1};
          4'h7: {d.op, d.fc, d.fdc, d.fz} = {ALU_ADD, 3'b111};
          4'h8: {d.op, d.fz} = {ALU_PSB, 1'b1};
          4'h9: {d.op, d.fz} = {ALU_COM, 1'b1};
          4'ha: {d.op, d.fz} = {ALU_INC, 1'b1};
          4'hb: {d.op, d.flow} = {ALU_DEC, FL_SKZ};
          4'hc: {d.op, d.fc} = {ALU_RRF, 1'b1};
          4'hd: {d.op, d.fc} = {ALU_RLF, 1'b1};
          4'he: d.op = ALU_SWP;
          4'hf: {d.op, d.flow} = {ALU_INC, FL_SKZ};
        endcase
      end
      2'b01: begin
        d.rd_f = 1'b1;
        unique case (i[11:10])
          2'b00: {d.op, d.wr_f} = {ALU_BCL, 1'b1};
          2'b01: {d.op, d.wr_f} = {ALU_BST, 1'b1};
          2'b10: {d.flow, d.skip_set} = {FL_SKB, 1'b0};
          2'b11: {d.flow, d.skip_set} = {FL_SKB, 1'b1};
        endcase
      end
      2'b10: d.flow = i[11] ? FL_GOTO : FL_CALL;
      2'b11: begin
        d.lit = 1'b1;
        d.wr_w = 1'b1;
        unique casez (i[11:8])
          4'b00??: d.op = ALU_PSB;
          4'b01??: d.flow = FL_RETLW;
          4'b1000: {d.op, d.fz} = {ALU_IOR, 1'b1};
          4'b1001: {d.op, d.fz} = {ALU_AND, 1'b1};
          4'b1010: {d.op, d.fz} = {ALU_XOR, 1'b1};
          4'b1011: d.op = ALU_PSB;
          4'b110?: {d.op, d.fc, d.fdc, d.fz} = {ALU_SUB, 3'b111};
          4'b111?: {d.op, d.fc, d.fdc, d.fz} = {ALU_ADD, 3'b111};
        endcase
      end
    endcase
    return d;
  endfunction : ccp_decode

  // ==========================================================
  // state
  ccp_phase_e  ph_r, ph_nxt;
  logic [12:0] pc_r;
  logic [13:0] ir_r;              // instruction latch
  logic        ir_vld_r;
  logic [7:0]  w_r;               // working accumulator, not file mapped
  logic [7:0]  opr_r;
  logic [7:0]  fsr_r;
  logic [4:0]  pclath_r;
  logic [1:0]  st_up_r;
  logic        rp0_r;
  logic        c_r;
  logic        dc_r;
  logic        z_r;
  logic [12:0] stk_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [7:0]  alu_y;
  logic        alu_c;
  logic        alu_dc;
  logic        alu_z;

  // ==========================================================
  // phase generator: a one-hot ring so the four phases never overlap
  always_comb begin
    unique case (ph_r)
      PH_ONE:   ph_nxt = PH_TWO;
      PH_TWO:   ph_nxt = PH_THREE;
      PH_THREE: ph_nxt = PH_FOUR;
      PH_FOUR:  ph_nxt = PH_ONE;
      default:  ph_nxt = PH_ONE;
    endcase
  end

  wire logic t1 = clk_en && (ph_r == PH_ONE);
  wire logic t2 = clk_en && (ph_r == PH_TWO);
  wire logic t3 = clk_en && (ph_r == PH_THREE);
  wire logic t4 = clk_en && (ph_r == PH_FOUR);

  // async clear holds every flop except the stack words while master clear is low
  always_ff @(posedge ref_clk or negedge nrst) begin                // RQ18
    if (!nrst) begin
      ph_r <= PH_ONE;                                               // RQ21
      oscillator_output_cycle_clock <= 1'b0;
    end else if (clk_en) begin
      ph_r <= ph_nxt;                                               // RQ1
      // high in phases one and two: a quarter-rate cycle clock
      oscillator_output_cycle_clock <= resistor_capacitor_oscillator_mode &&
        (ph_nxt == PH_ONE || ph_nxt == PH_TWO);                     // RQ17
    end
  end

  assign phase_one   = ph_r[0];
  assign phase_two   = ph_r[1];
  assign phase_three = ph_r[2];
  assign phase_four  = ph_r[3];

  // ==========================================================
  // operand decode and file address; a flushed slot executes as a no-op
  wire ccp_dec_s   dx    = ir_vld_r ? ccp_decode(ir_r) : ccp_decode(14'h0000);
  wire logic       ind   = (ir_r[6:0] == FA_INDF);
  wire logic [7:0] faddr = ind ? fsr_r : {rp0_r, ir_r[6:0]};         // RQ16
  wire logic [6:0] fl    = faddr[6:0];
  wire logic       f_int = fl inside {FA_INDF, FA_PCL, FA_STATUS, FA_FSR, FA_PCLATH};
  wire logic [7:0] st_v  = {st_up_r, rp0_r, ST_PWR_RD, z_r, dc_r, c_r};
  // core locations answer from here, the rest from the data memory
  wire logic [7:0] int_rd = (fl == FA_PCL)    ? preq.addr[7:0] :
                            (fl == FA_STATUS) ? st_v :
                            (fl == FA_FSR)    ? fsr_r :
                            (fl == FA_PCLATH) ? {3'h0, pclath_r} : 8'h00;

  // ==========================================================
  // arithmetic unit: accumulator against file operand or literal
  wire logic [7:0] alu_b = dx.lit ? ir_r[7:0] : opr_r;              // RQ13

  ccp_alu u_alu (
    .op     (dx.op),
    .a      (w_r),                                                  // RQ14
    .b      (alu_b),
    .bsel   (ir_r[9:7]),
    .c_in   (c_r),
    .y      (alu_y),
    .c_out  (alu_c),
    .dc_out (alu_dc),
    .z_out  (alu_z)
  );

  // ==========================================================
  // flow control at the end of execution
  wire logic jmp_gc  = dx.flow inside {FL_GOTO, FL_CALL};
  wire logic jmp_rt  = dx.flow inside {FL_RET, FL_RETLW, FL_RETFIE};
  wire logic pcl_wr  = dx.wr_f && (fl == FA_PCL);
  wire logic st_wr   = dx.wr_f && (fl == FA_STATUS);
  wire logic bit_v   = opr_r[ir_r[9:7]];
  wire logic skip    = (dx.flow == FL_SKZ && alu_z) ||
                       (dx.flow == FL_SKB && bit_v == dx.skip_set);
  wire logic jump    = jmp_gc || jmp_rt || pcl_wr;
  // interrupts wait for a plain instruction so no return address is lost
  wire logic int_take = int_req && ir_vld_r && !jump && !skip;
  wire logic flush   = jump || skip || int_take;
  wire logic push    = (dx.flow == FL_CALL) || int_take;
  wire logic [SP_W-1:0] sp_top = sp_r - SP_W'(1);
  wire logic [12:0] pc_tgt = jmp_gc   ? {pclath_r[4:3], ir_r[10:0]} :
                             jmp_rt   ? stk_r[sp_top] :
                             int_take ? INT_VEC : {pclath_r, alu_y};

  // program counter and fetch; the program bus is 14 bits wide
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_r     <= RESET_VEC;                                        // RQ19
      preq     <= '0;
      ir_r     <= 14'h0000;
      ir_vld_r <= 1'b0;                                             // RQ21
    end else if (t1) begin
      pc_r      <= pc_r + 13'h1;                                    // RQ2
      preq.addr <= pc_r & PC_MASK;                                  // RQ20
      preq.rd   <= 1'b1;
    end else if (t4) begin
      if (jump || int_take) pc_r <= pc_tgt;                         // RQ8
      ir_r     <= prog_data;                                        // RQ3 RQ9
      ir_vld_r <= !flush;                                           // RQ7 RQ8
      preq.rd  <= 1'b0;
    end
  end

  // return stack: circular, overflow silently overwrites the oldest
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sp_r <= '0;
    end else if (t4 && push) begin
      sp_r <= sp_r + SP_W'(1);
    end else if (t4 && jmp_rt) begin
      sp_r <= sp_top;
    end
  end

  // stack words carry no reset, only the pointer needs one
  always_ff @(posedge ref_clk) begin
    if (t4 && push) begin
      stk_r[sp_r] <= preq.addr;
    end
  end

  // ==========================================================
  // data memory strobes: read in phase two, write in phase four
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dreq <= '0;
    end else if (t1) begin
      dreq.addr <= faddr;
      dreq.rd   <= dx.rd_f && !f_int;                               // RQ5
    end else if (t2) begin
      dreq.rd <= 1'b0;
    end else if (t3) begin
      dreq.wr    <= dx.wr_f && !f_int;                              // RQ6
      dreq.wdata <= alu_y;
    end else if (t4) begin
      dreq.wr <= 1'b0;
    end
  end

  // operand capture at the end of phase two
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      opr_r <= 8'h00;
    end else if (t2) begin
      opr_r <= f_int ? int_rd : dmem_rdata;                         // RQ5 RQ4
    end
  end

  // ==========================================================
  // execute write-back in phase four; instruction flags beat a status write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_r      <= W_RST;
      fsr_r    <= FSR_RST;
      pclath_r <= PCLATH_RST;
      st_up_r  <= 2'h0;
      rp0_r    <= 1'b0;
      c_r      <= 1'b0;
      dc_r     <= 1'b0;
      z_r      <= 1'b0;
    end else if (t4) begin
      if (dx.wr_w) w_r <= alu_y;                                    // RQ4
      if (dx.wr_f && fl == FA_FSR) fsr_r <= alu_y;                  // RQ16
      if (dx.wr_f && fl == FA_PCLATH) pclath_r <= alu_y[4:0];
      if (st_wr) {st_up_r, rp0_r} <= alu_y[7:ST_RP0];
      if (dx.fc) c_r <= alu_c;                                      // RQ15
      else if (st_wr) c_r <= alu_y[ST_C];
      if (dx.fdc) dc_r <= alu_dc;                                   // RQ15
      else if (st_wr) dc_r <= alu_y[ST_DC];
      if (dx.fz) z_r <= alu_z;                                      // RQ15
      else if (st_wr) z_r <= alu_y[ST_Z];
    end
  end

  // one-cycle notices to the interrupt logic
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_ack      <= 1'b0;
      retfie_pulse <= 1'b0;
    end else if (clk_en) begin
      int_ack      <= t4 && int_take;                               // RQ19
      retfie_pulse <= t4 && dx.flow == FL_RETFIE;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_run4;
    (ph_r == PH_ONE && clk_en) ##1 clk_en [*3];
  endsequence

  property p_phase_ring;
    s_run4 |=> (ph_r == PH_ONE) && ($past(ph_r) == PH_FOUR);
  endproperty
  a_phase_ring: assert property (p_phase_ring) else $error("phase ring broken"); // RQ1

  property p_pc_adv;
    t1 |=> pc_r == $past(pc_r) + 13'h1;
  endproperty
  a_pc_adv: assert property (p_pc_adv) else $error("pc did not advance"); // RQ2

  property p_fetch;
    t4 |=> ir_r == $past(prog_data);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not latched"); // RQ3

  property p_rd_phase;
    dreq.rd |-> ph_r == PH_TWO;
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read out of phase"); // RQ5

  property p_wr_phase;
    dreq.wr |-> ph_r == PH_FOUR && dreq.wdata == $past(alu_y);
  endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write out of phase"); // RQ6

  property p_rate;
    (t4 && !flush) |=> ir_vld_r;
  endproperty
  a_rate: assert property (p_rate) else $error("plain slot lost"); // RQ7

  property p_flush;
    (t4 && jump) |=> !ir_vld_r && pc_r == $past(pc_tgt);
  endproperty
  a_flush: assert property (p_flush) else $error("branch not flushed"); // RQ8

  property p_cyc_clk;
    (t4 && resistor_capacitor_oscillator_mode) ##1
      (clk_en && resistor_capacitor_oscillator_mode) |=>
      oscillator_output_cycle_clock && ph_r == PH_TWO;
  endproperty
  a_cyc_clk: assert property (p_cyc_clk) else $error("cycle clock wrong"); // RQ17

  property p_int_vec;
    (t4 && int_take) |=> pc_r == INT_VEC && int_ack && !ir_vld_r;
  endproperty
  a_int_vec: assert property (p_int_vec) else $error("interrupt vector"); // RQ19

  property p_wrap;
    (preq.addr & ~PC_MASK) == 13'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address beyond memory"); // RQ20

  property p_sub_c;
    (dx.op == ALU_SUB) |-> alu_c == (alu_b >= w_r);
  endproperty
  a_sub_c: assert property (p_sub_c) else $error("borrow sense wrong"); // RQ15

endmodule : ccp_core

`default_nettype wire

// file: hw/ccp_pkg.sv
// ccp_pkg: shared constants, enums and carrier structs of the core
// assumes one clock (the oscillator input) and an active-low master clear
//
// Contract
// (RQ1) Oscillator input splits into four non-overlapping phases making one instruction cycle.
// (RQ2) Program counter advances by one in phase one, opening each fetch cycle.
// (RQ3) Fetched word is latched in phase four and executes from next phase one.
// (RQ4) Latched instruction decodes and executes over phases two, three and four.
// (RQ5) Register-file source operand is read in phase two.
// (RQ6) Register-file result is written in phase four.
// (RQ7) Fetch overlaps execute, so plain instructions finish one per cycle.
// (RQ8) Program counter changes take two cycles; the prefetched word is discarded.
// (RQ9) Each instruction is one 14-bit word on its own program bus.
// (RQ10) At 20 MHz input, 35 plain instructions each take one 200 ns cycle.
// (RQ11) Arithmetic unit is 8 bits wide: add, subtract, shift and logic.
// (RQ12) Arithmetic follows two's complement unless an instruction says otherwise.
// (RQ13) Two-operand ops use accumulator plus file or literal; single-operand ops either.
// (RQ14) Working accumulator is 8 bits, feeds the unit, and has no address.
// (RQ15) Carry, half-carry, zero update per instruction; subtract carries are inverted borrows.
// (RQ16) Special registers, program counter low byte too, are ordinary file locations.
// (RQ17) In resistor-capacitor mode the output pin runs at quarter input rate.
// (RQ18) Master clear held low resets the core.
// (RQ19) Execution starts at 0000h after reset; accepted interrupt goes to 0004h.
// (RQ20) Program counter is 13 bits; addresses wrap into implemented memory.
// (RQ21) Reset release restarts at phase one with no valid prefetched word.

package ccp_pkg;

  // ==========================================================
  // timing
  localparam int unsigned INSTR_CYCLE_NS = 200;
  localparam int unsigned OSC_NOM_MHZ    = 20;
  // oscillator periods in one instruction cycle
  localparam int unsigned PHASE_COUNT    = INSTR_CYCLE_NS * OSC_NOM_MHZ / 1000;

  // ==========================================================
  // vectors and reset values
  localparam logic [12:0] RESET_VEC  = 13'h0000;
  localparam logic [12:0] INT_VEC    = 13'h0004;
  localparam logic [7:0]  W_RST      = 8'h00;
  localparam logic [7:0]  FSR_RST    = 8'h00;
  localparam logic [4:0]  PCLATH_RST = 5'h00;

  // ==========================================================
  // core file locations (low seven address bits, both banks)
  localparam logic [6:0] FA_INDF   = 7'h00;
  localparam logic [6:0] FA_PCL    = 7'h02;
  localparam logic [6:0] FA_STATUS = 7'h03;
  localparam logic [6:0] FA_FSR    = 7'h04;
  localparam logic [6:0] FA_PCLATH = 7'h0a;

  // status field positions; the two power flags read as one here
  localparam int unsigned ST_C   = 0;
  localparam int unsigned ST_DC  = 1;
  localparam int unsigned ST_Z   = 2;
  localparam int unsigned ST_RP0 = 5;
  localparam logic [1:0]  ST_PWR_RD = 2'h3;

  // ==========================================================
  // enums
  typedef enum logic [3:0] {
    PH_ONE = 4'b0001, PH_TWO = 4'b0010, PH_THREE = 4'b0100, PH_FOUR = 4'b1000
  } ccp_phase_e;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_SUB = 4'h1, ALU_AND = 4'h2, ALU_IOR = 4'h3,
    ALU_XOR = 4'h4, ALU_COM = 4'h5, ALU_DEC = 4'h6, ALU_INC = 4'h7,
    ALU_PSB = 4'h8, ALU_PSA = 4'h9, ALU_RLF = 4'ha, ALU_RRF = 4'hb,
    ALU_SWP = 4'hc, ALU_CLR = 4'hd, ALU_BCL = 4'he, ALU_BST = 4'hf
  } ccp_alu_e;

  typedef enum logic [2:0] {
    FL_SEQ = 3'h0, FL_GOTO = 3'h1, FL_CALL = 3'h2, FL_RET = 3'h3,
    FL_RETLW = 3'h4, FL_RETFIE = 3'h5, FL_SKZ = 3'h6, FL_SKB = 3'h7
  } ccp_flow_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    ccp_alu_e  op;
    ccp_flow_e flow;
    logic      lit;      // second operand is the literal
    logic      rd_f;     // reads a file location
    logic      wr_f;     // result to file
    logic      wr_w;     // result to accumulator
    logic      fz;
    logic      fc;
    logic      fdc;
    logic      skip_set; // bit test skips when bit is one
  } ccp_dec_s;

  typedef struct packed {
    logic [12:0] addr;
    logic        rd;
  } ccp_preq_s;

  typedef struct packed {
    logic [7:0] addr;    // {bank, location}
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } ccp_dreq_s;

endpackage : ccp_pkg

// file: test/ccp_mem_model.sv
// ccp_mem_model: program memory and data memory beside the core
// assumes the bench loads rom and ram by hierarchical reference
`timescale 1ns/1ps
`default_nettype none

module ccp_mem_model
  import ccp_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire ccp_preq_s preq,
  input  wire ccp_dreq_s dreq,
  output logic [13:0]    prog_data,
  output logic [7:0]     dmem_rdata
);
  // ==========================================================
  // storage
  logic [13:0] rom [0:8191];
  logic [7:0]  ram [0:255];
  logic [7:0]  last_r = 8'h00;

  // outside a fetch or read the lines flip, so a late sample is caught
  assign prog_data  = preq.rd ? rom[preq.addr] : ~rom[preq.addr];
  assign dmem_rdata = dreq.rd ? ram[dreq.addr] : ~last_r;

  // write lands at the edge ending the strobe
  always @(posedge ref_clk) begin
    if (dreq.rd) last_r <= ram[dreq.addr];
    if (dreq.wr) ram[dreq.addr] <= dreq.wdata;
  end
endmodule : ccp_mem_model
`default_nettype wire

// file: test/tb_cpu_core_clock_pipeline.sv
// tb_cpu_core_clock_pipeline: scenario tasks for the core
// assumes ccp_pkg and ccp_core compiled first; interrupts raised only in t_irq
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_core_clock_pipeline;
  import ccp_pkg::*;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_en = 1'b1;
  logic        rc_mode = 1'b1;
  logic        int_req = 1'b0;
  logic        int_ack, retfie_pulse;
  logic [13:0] prog_data;
  logic [7:0]  dmem_rdata;
  ccp_preq_s   preq;
  ccp_dreq_s   dreq;
  logic        p1, p2, p3, p4, clkout;
  int          mismatches = 0;
  int          check_count = 0;
  logic [12:0] fq[$];
  logic [3:0]  ph;

  ccp_core DUT (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .resistor_capacitor_oscillator_mode(rc_mode), .prog_data(prog_data),
    .dmem_rdata(dmem_rdata), .int_req(int_req), .preq(preq), .dreq(dreq),
    .phase_one(p1), .phase_two(p2), .phase_three(p3), .phase_four(p4),
    .oscillator_output_cycle_clock(clkout), .int_ack(int_ack),
    .retfie_pulse(retfie_pulse));
  ccp_mem_model mem (.ref_clk(ref_clk), .preq(preq), .dreq(dreq),
    .prog_data(prog_data), .dmem_rdata(dmem_rdata));

  // ==========================================================
  // clock, watchdog, reporting
  always #2.5 ref_clk = ~ref_clk;
  initial begin
    #(5 * 3000);
    mismatches++;
    close_out();
  end

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic close_out();
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // strobes only in their own phase; fetch address logged once per cycle
  always @(negedge ref_clk) begin
    if (nrst && dreq.rd) check_val("rd_phase", 16'h1, p2);
    if (nrst && dreq.wr) check_val("wr_phase", 16'h1, p4);
    if (nrst && p2) fq.push_back(preq.addr);
  end

  // ==========================================================
  // scenarios
  // unknown words would poison decode, so every scenario starts from no-ops
  task automatic blank_mem();
    for (int i = 0; i < 256; i++) mem.ram[i] = 8'h00;
    for (int i = 0; i < 8192; i++) mem.rom[i] = 14'h0000;
  endtask : blank_mem

  task automatic do_reset();
    nrst = 1'b0;
    int_req = 1'b0;
    repeat (12) @(negedge ref_clk);
    check_val("rst_phase", 16'h1, {p4, p3, p2, p1});
    check_val("rst_fetch", 16'h0, {preq.addr, preq.rd});
    nrst = 1'b1;
    fq.delete();
  endtask : do_reset

  // phase rotation, cycle clock and freeze by clk_en
  task automatic t_phases();
    blank_mem();
    do_reset();
    for (int k = 0; k < 12; k++) begin
      check_val("phase", 16'h1 << (k % 4), {p4, p3, p2, p1});
      if (k >= 4) check_val("clkout", 16'(k % 4 < 2), clkout);
      if (k == 1) check_val("fetch0", 16'h1, {preq.addr, preq.rd});
      @(negedge ref_clk);
    end
    ph = {p4, p3, p2, p1};
    clk_en = 1'b0;
    repeat (3) @(negedge ref_clk);
    check_val("frozen", 16'(ph), {p4, p3, p2, p1});
    clk_en = 1'b1;
    rc_mode = 1'b0;
    repeat (2) @(negedge ref_clk);
    check_val("clkout_off", 16'h0, clkout);
    rc_mode = 1'b1;
  endtask : t_phases

  // add, subtract, status read, jump with flushed slot
  task automatic t_program();
    logic [12:0] exp_f [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 'h10, 'h11, 'h12, 'h11};
    blank_mem();
    mem.rom[0] = 14'h3025;    // load literal 25
    mem.rom[1] = 14'h00a0;    // store to 20
    mem.rom[2] = 14'h07a0;    // add into 20
    mem.rom[3] = 14'h0220;    // 20 minus acc into acc
    mem.rom[4] = 14'h0803;    // status into acc
    mem.rom[5] = 14'h00a1;
    mem.rom[6] = 14'h2810;    // jump to 10
    mem.rom[7] = 14'h00a3;    // prefetched, must be dropped
    mem.rom['h10] = 14'h00a2;
    mem.rom['h11] = 14'h2811; // spin
    do_reset();
    for (int i = 0; i < 100 && fq.size() < 12; i++) @(negedge ref_clk);
    for (int i = 0; i < 12; i++) check_val("fetch", 16'(exp_f[i]), 16'(fq[i]));
    check_val("sum", 16'h4a, mem.ram['h20]);
    check_val("flags", 16'h1b, mem.ram['h21]);
    check_val("after_jump", 16'h1b, mem.ram['h22]);
    check_val("flushed", 16'h00, mem.ram['h23]);
  endtask : t_program

  // interrupt taken after the first no-op, vector, then return through the stack
  task automatic t_irq();
    logic [12:0] exp_f [8] = '{0, 1, 4, 5, 1, 2, 3, 4};
    int          n_ack = 0;
    int          n_ret = 0;
    blank_mem();
    mem.rom[3] = 14'h2803;    // spin, keeps the vector word from running again
    mem.rom[4] = 14'h0009;    // return from interrupt
    do_reset();
    int_req = 1'b1;
    for (int i = 0; i < 100 && fq.size() < 8; i++) begin
      @(negedge ref_clk);
      if (int_ack === 1'b1) int_req = 1'b0;
      if (int_ack === 1'b1) n_ack++;
      if (retfie_pulse === 1'b1) n_ret++;
    end
    for (int i = 0; i < 8; i++) check_val("irq_fetch", 16'(exp_f[i]), 16'(fq[i]));
    check_val("int_ack", 16'h1, 16'(n_ack));
    check_val("retfie", 16'h1, 16'(n_ret));
  endtask : t_irq

  initial begin
    @(negedge ref_clk);
    t_phases();
    t_program();
    t_irq();
    t_program(); // second pass resets a running core
    close_out();
  end
endmodule : tb_cpu_core_clock_pipeline
`default_nettype wire
